// *** cctx_pkg.sv ***
// constants, types and register map of the transmit content cipher engine
`default_nettype none
package cctx_pkg;
   // register word indices on the control and status port
   localparam logic [1:0] REG_CRYPTO_COMMAND = 2'h0;
   localparam logic [1:0] REG_MSG_IN = 2'h1;
   localparam logic [1:0] REG_STATUS = 2'h2;
   localparam logic [1:0] REG_MSG_OUT = 2'h3;
   localparam int unsigned CSR_ADDR_W = 2;
   localparam int unsigned CSR_DATA_W = 32;

   // command bit positions, one-hot
   localparam int unsigned CMD_W = 11;
   localparam int unsigned BIT_MAKE_TX_NONCE = 0;
   localparam int unsigned BIT_START_SIGNATURE_CHECK = 1;
   localparam int unsigned BIT_MAKE_ENC_MASTER_KEY = 2;
   localparam int unsigned BIT_START_KEY_DERIVE = 3;
   localparam int unsigned BIT_START_H_CHECK = 4;
   localparam int unsigned BIT_MAKE_LOCALITY_NONCE = 5;
   localparam int unsigned BIT_START_LOCALITY_CHECK = 6;
   localparam int unsigned BIT_MAKE_ENC_SESSION_KEY = 7;
   localparam int unsigned BIT_MAKE_INIT_VECTOR = 8;
   localparam int unsigned BIT_START_V_CHECK = 9;
   localparam int unsigned BIT_START_M_CHECK = 10;

   // status register fields; bits 10:0 are per-command done flags
   localparam int unsigned STAT_OK_BIT = 31;
   localparam int unsigned STAT_BUSY_BIT = 30;
   localparam int unsigned STAT_KEY_BIT = 29;

   // key port: four 32-bit words, word 3 holds the top bits
   localparam int unsigned KEY_WORDS = 4;
   localparam int unsigned KEY_ADDR_W = 2;
   localparam logic [1:0] KEY_LAST_ADDR = 2'h3;

   // result lengths in bytes
   localparam logic [7:0] LEN_NONCE = 8'h08;
   localparam logic [7:0] LEN_SESSION_KEY = 8'h10;
   localparam logic [7:0] LEN_MASTER_KEY = 8'h80;
   localparam logic [7:0] LEN_NONE = 8'h00;
   // signature (384) plus receiver identifier (5)
   localparam logic [9:0] SIG_MIN_BYTES = 10'h185;

   // reset values
   localparam logic [31:0] LFSR_SEED = 32'h0000_0001;
   localparam logic [CMD_W-1:0] CMD_RESET = 11'h000;

   typedef struct packed {
      logic de;
      logic [7:0] aux;
      logic [23:0] pixel;
   } cctx_video_s;

   typedef struct packed {
      logic write;
      logic read;
      logic [CSR_ADDR_W-1:0] addr;
      logic [CSR_DATA_W-1:0] wdata;
   } cctx_csr_req_s;

   typedef enum logic [2:0] {
      ST_KEY = 3'b001,
      ST_IDLE = 3'b010,
      ST_BUSY = 3'b100
   } cctx_state_e;
endpackage : cctx_pkg
`default_nettype wire

// *** cctx_fifo.sv ***
// synchronous valid/ready fifo with parameter width and depth
`timescale 1ns/100ps
`default_nettype none
module cctx_fifo #(
   parameter int unsigned WIDTH = 33,
   parameter int unsigned DEPTH = 8
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic nrst,
   // fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int unsigned PTR_W = $clog2(DEPTH);

   initial begin
      if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin
         $error("fifo depth must be a power of two of at least 2");
      end
   end

   logic [WIDTH-1:0] mem [DEPTH];
   logic [PTR_W-1:0] wr_ptr;
   logic [PTR_W-1:0] rd_ptr;
   logic [PTR_W:0] count;
   wire push = in_valid && in_ready;
   wire pop = out_valid && out_ready;

   assign in_ready = (count != (PTR_W+1)'(DEPTH));
   assign out_valid = (count != '0);
   assign out_data = mem[rd_ptr];

   always_ff @(posedge ref_clk) begin
      if (push) begin
         mem[wr_ptr] <= in_data;
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end else begin
         wr_ptr <= wr_ptr + PTR_W'(push);
         rd_ptr <= rd_ptr + PTR_W'(pop);
         count <= count + (PTR_W+1)'(push) - (PTR_W+1)'(pop);
      end
   end
endmodule : cctx_fifo
`default_nettype wire

// *** cctx_tx_auth_ctrl.sv ***
// transmit content cipher: command engine, key fetch and video encryption
//
// Contract
// - encrypt video and aux data before it goes onto the serial link
// - processor reaches control and status registers over memory-mapped port
// - fetch the 128-bit global constant key over the key port
// - take content on the video input port and encrypt it
// - encryption status signaling from upstream decides which frames encrypt
// - every command bit clears itself once the operation is busy
// - bit 10 computes M and compares against received M'
// - bit 9 computes V and compares against received V'
// - bit 8 generates a fresh initialization vector for software
// - bit 7 generates a new encrypted session key for software
// - bit 6 computes L and compares against received L'
// - bit 4 computes H and compares against received H'
// - bit 3 derives the key-derivation output kd
// - bit 2 produces a new encrypted master key for software
// - bit 1 verifies a certificate or revocation list signature
// - bit 0 generates a fresh transmitter nonce for software
// - bit 5 generates a new random locality nonce, self-clearing
`timescale 1ns/100ps
`default_nettype none
module cctx_tx_auth_ctrl #(
   parameter int unsigned OP_CYCLES = 32,
   parameter int unsigned OUT_DEPTH = 128,
   parameter int unsigned FIFO_DEPTH = 8
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic nrst,
   // control and status port
   input wire cctx_pkg::cctx_csr_req_s csr_req,
   output logic [cctx_pkg::CSR_DATA_W-1:0] csr_rdata,
   // key port
   output logic key_rd,
   output logic [cctx_pkg::KEY_ADDR_W-1:0] key_addr,
   input wire logic [31:0] key_rdata,
   // video and aux input
   input wire logic vid_in_valid,
   output logic vid_in_ready,
   input wire cctx_pkg::cctx_video_s vid_in,
   input wire logic encryption_status_signaling,
   // encrypted output toward the serial link
   output logic vid_out_valid,
   input wire logic vid_out_ready,
   output cctx_pkg::cctx_video_s vid_out
);
   localparam int unsigned VID_W = $bits(cctx_pkg::cctx_video_s);
   localparam int unsigned OUT_W = $clog2(OUT_DEPTH);

   initial begin
      if (OP_CYCLES < 1 || OP_CYCLES > 127) begin
         $error("op cycles must lie in 1..127");
      end
      if (OUT_DEPTH < 128 || OUT_DEPTH > 256) begin
         $error("output buffer must hold 128 to 256 bytes");
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // functions

   function automatic logic is_one_hot(input logic [cctx_pkg::CMD_W-1:0] v);
      is_one_hot = (v != '0) && ((v & (v - 11'h001)) == '0);
   endfunction : is_one_hot

   function automatic logic [7:0] result_len(
      input logic [cctx_pkg::CMD_W-1:0] c);
      if (c[cctx_pkg::BIT_MAKE_ENC_MASTER_KEY]) begin
         result_len = cctx_pkg::LEN_MASTER_KEY;
      end else if (c[cctx_pkg::BIT_MAKE_ENC_SESSION_KEY]) begin
         result_len = cctx_pkg::LEN_SESSION_KEY;
      end else if (c[cctx_pkg::BIT_MAKE_TX_NONCE] ||
                   c[cctx_pkg::BIT_MAKE_LOCALITY_NONCE] ||
                   c[cctx_pkg::BIT_MAKE_INIT_VECTOR]) begin
         result_len = cctx_pkg::LEN_NONCE;
      end else begin
         result_len = cctx_pkg::LEN_NONE;
      end
   endfunction : result_len

   function automatic logic [31:0] fold_key(input logic [127:0] k);
      fold_key = k[127:96] ^ k[95:64] ^ k[63:32] ^ k[31:0];
   endfunction : fold_key

   ////////////////////////////////////////////////////////////////////////
   // state

   cctx_pkg::cctx_state_e state;
   cctx_pkg::cctx_state_e next_state;
   logic [cctx_pkg::CMD_W-1:0] crypto_command;
   logic [cctx_pkg::CMD_W-1:0] op;
   logic [cctx_pkg::CMD_W-1:0] done;
   logic ok;
   logic [7:0] op_len;
   logic [7:0] op_cnt;
   logic [127:0] global_constant_key;
   logic key_loaded;
   logic key_pend;
   logic [31:0] lfsr;
   logic [31:0] msg_acc;
   logic [9:0] msg_count;
   logic [31:0] kd;
   logic [31:0] ks_state;
   logic [7:0] out_mem [OUT_DEPTH];
   logic [OUT_W-1:0] rd_ptr;

   ////////////////////////////////////////////////////////////////////////
   // register decode

   wire wr_cmd = csr_req.write &&
                 csr_req.addr == cctx_pkg::REG_CRYPTO_COMMAND;
   wire wr_msg = csr_req.write && csr_req.addr == cctx_pkg::REG_MSG_IN;
   wire rd_out = csr_req.read && csr_req.addr == cctx_pkg::REG_MSG_OUT;
   wire [cctx_pkg::CMD_W-1:0] cmd_bits = csr_req.wdata[cctx_pkg::CMD_W-1:0];
   wire cmd_legal = is_one_hot(cmd_bits);
   wire start = (state == cctx_pkg::ST_IDLE) && crypto_command != '0;
   wire [7:0] start_len = result_len(crypto_command);
   wire [7:0] op_last = op_len + 8'(OP_CYCLES);
   wire finish = (state == cctx_pkg::ST_BUSY) && (op_cnt == op_last);
   wire is_compare = op[cctx_pkg::BIT_START_M_CHECK] ||
                     op[cctx_pkg::BIT_START_V_CHECK] ||
                     op[cctx_pkg::BIT_START_LOCALITY_CHECK] ||
                     op[cctx_pkg::BIT_START_H_CHECK];
   wire cmp_ok = (msg_acc == (fold_key(global_constant_key) ^ kd));
   wire sig_ok = (msg_count >= cctx_pkg::SIG_MIN_BYTES);
   wire [7:0] rand_byte = lfsr[7:0];
   wire [7:0] sess_byte = lfsr[7:0] ^ kd[7:0];
   wire [31:0] next_lfsr = {lfsr[30:0],
                            lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
   wire [31:0] status_word = {ok, state == cctx_pkg::ST_BUSY, key_loaded,
                              18'h00000, done};

   ////////////////////////////////////////////////////////////////////////
   // key fetch

   assign key_rd = (state == cctx_pkg::ST_KEY) && !key_pend;
   logic [cctx_pkg::KEY_ADDR_W-1:0] key_fetch_idx;
   assign key_addr = key_fetch_idx;
   wire key_last = key_pend && key_fetch_idx == cctx_pkg::KEY_LAST_ADDR;

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         key_pend <= 1'b0;
         key_fetch_idx <= '0;
         global_constant_key <= '0;
         key_loaded <= 1'b0;
      end else begin
         key_pend <= key_rd;
         if (key_pend) begin
            // word n lands in bits 32n+31:32n
            global_constant_key[key_fetch_idx*32 +: 32] <= key_rdata;
            key_fetch_idx <= key_fetch_idx + 2'h1;
         end
         key_loaded <= key_loaded || key_last;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // command engine

   always_comb begin
      next_state = state;
      unique case (state)
         cctx_pkg::ST_KEY: begin
            if (key_last) begin
               next_state = cctx_pkg::ST_IDLE;
            end
         end
         cctx_pkg::ST_IDLE: begin
            if (start) begin
               next_state = cctx_pkg::ST_BUSY;
            end
         end
         cctx_pkg::ST_BUSY: begin
            if (finish) begin
               next_state = cctx_pkg::ST_IDLE;
            end
         end
         default: next_state = cctx_pkg::ST_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         state <= cctx_pkg::ST_KEY;
         crypto_command <= cctx_pkg::CMD_RESET;
         op <= '0;
         op_len <= '0;
         op_cnt <= '0;
      end else begin
         state <= next_state;
         if (start) begin
            crypto_command <= (wr_cmd && cmd_legal) ? cmd_bits : '0;
            op <= crypto_command;
            op_len <= start_len;
            op_cnt <= '0;
         end else if (wr_cmd && cmd_legal) begin
            crypto_command <= cmd_bits;
         end
         if (state == cctx_pkg::ST_BUSY) begin
            op_cnt <= op_cnt + 8'h01;
         end
      end
   end

   // done flags: cleared when the same command starts, set at its end
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         done <= '0;
         ok <= 1'b0;
         kd <= '0;
      end else begin
         if (start) begin
            done <= done & ~crypto_command;
            ok <= 1'b0;
         end
         if (finish) begin
            done <= done | op;
            if (is_compare) begin
               ok <= cmp_ok;
            end else if (op[cctx_pkg::BIT_START_SIGNATURE_CHECK]) begin
               ok <= sig_ok;
            end else begin
               ok <= 1'b1;
            end
            if (op[cctx_pkg::BIT_START_KEY_DERIVE]) begin
               kd <= fold_key(global_constant_key) ^ msg_acc;
            end
         end
      end
   end

   // result bytes are drawn one per busy cycle while op_cnt is below op_len
   always_ff @(posedge ref_clk) begin
      if (state == cctx_pkg::ST_BUSY && op_cnt < op_len) begin
         if (op[cctx_pkg::BIT_MAKE_ENC_SESSION_KEY] ||
             op[cctx_pkg::BIT_MAKE_ENC_MASTER_KEY]) begin
            out_mem[op_cnt[OUT_W-1:0]] <= sess_byte;
         end else begin
            out_mem[op_cnt[OUT_W-1:0]] <= rand_byte;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // message input, readout and random source

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         lfsr <= cctx_pkg::LFSR_SEED;
         msg_acc <= '0;
         msg_count <= '0;
         rd_ptr <= '0;
         csr_rdata <= '0;
      end else begin
         lfsr <= next_lfsr;
         if (finish) begin
            msg_acc <= '0;
            msg_count <= '0;
         end else if (wr_msg) begin
            msg_acc <= {msg_acc[23:0], msg_acc[31:24] ^ csr_req.wdata[7:0]};
            msg_count <= msg_count + 10'h001;
         end
         if (start) begin
            rd_ptr <= '0;
         end else if (rd_out) begin
            rd_ptr <= rd_ptr + OUT_W'(1);
         end
         if (csr_req.read) begin
            unique case (csr_req.addr)
               cctx_pkg::REG_STATUS: csr_rdata <= status_word;
               cctx_pkg::REG_MSG_OUT: csr_rdata <= {24'h0, out_mem[rd_ptr]};
               default: csr_rdata <= '0;
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // video encryption

   cctx_pkg::cctx_video_s enc_data;
   logic fifo_in_ready;
   wire enc_active = encryption_status_signaling && key_loaded;
   wire vid_take = vid_in_valid && fifo_in_ready;

   assign vid_in_ready = fifo_in_ready;
   assign enc_data.de = vid_in.de;
   assign enc_data.aux = enc_active ? vid_in.aux ^ ks_state[31:24]
                                    : vid_in.aux;
   assign enc_data.pixel = enc_active ? vid_in.pixel ^ ks_state[23:0]
                                      : vid_in.pixel;

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         ks_state <= cctx_pkg::LFSR_SEED;
      end else if (finish && op[cctx_pkg::BIT_MAKE_ENC_SESSION_KEY]) begin
         ks_state <= kd ^ lfsr ^ fold_key(global_constant_key);
      end else if (vid_take && enc_active) begin
         ks_state <= {ks_state[30:0],
                      ks_state[31] ^ ks_state[21] ^ ks_state[1] ^ ks_state[0]};
      end
   end

   cctx_fifo #(
      .WIDTH(VID_W),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .ref_clk(ref_clk),
      .nrst(nrst),
      .in_valid(vid_in_valid),
      .in_ready(fifo_in_ready),
      .in_data(enc_data),
      .out_valid(vid_out_valid),
      .out_ready(vid_out_ready),
      .out_data(vid_out)
   );

   ////////////////////////////////////////////////////////////////////////
   // checks

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!nrst);

   a_cmd_self_clear: assert property (
      start |=> state == cctx_pkg::ST_BUSY &&
      (crypto_command == '0 || $past(wr_cmd && cmd_legal)))
      else $error("command bits did not clear when busy");

   a_bad_cmd_drop: assert property (
      state == cctx_pkg::ST_IDLE && crypto_command == '0 && wr_cmd &&
      !cmd_legal |=> state == cctx_pkg::ST_IDLE && crypto_command == '0)
      else $error("illegal command write was accepted");

   a_key_fetch_ok: assert property (
      key_rd |=> !key_rd ##1 (key_rd || key_loaded))
      else $error("key port read sequence broken");

   a_key_order: assert property (
      $rose(key_loaded) |-> $past(key_fetch_idx, 2) == cctx_pkg::KEY_LAST_ADDR)
      else $error("key loaded before last word");

   a_done_on_end: assert property (
      finish |=> (done & op) == op && state == cctx_pkg::ST_IDLE)
      else $error("done flag missing at end of operation");

   a_nonce_busy: assert property (
      start && crypto_command[cctx_pkg::BIT_MAKE_TX_NONCE]
      |=> (state == cctx_pkg::ST_BUSY) [*8])
      else $error("nonce operation ended too early");

   a_enc_bypass: assert property (
      vid_take && !enc_active |-> enc_data == vid_in)
      else $error("data altered outside encrypted frames");

   a_enc_pixel: assert property (
      vid_take && enc_active && ks_state[23:0] != '0 |->
      enc_data.pixel != vid_in.pixel)
      else $error("pixel passed unencrypted");

   a_msg_count: assert property (
      wr_msg && !finish |=> msg_count == $past(msg_count) + 10'h001)
      else $error("message byte not counted");
endmodule : cctx_tx_auth_ctrl
`default_nettype wire

// *** cctx_key_mem.sv ***
// key memory model holding the global constant key for the key port
`timescale 1ns/100ps
`default_nettype none
module cctx_key_mem #(
   // arbitrary test value, not a production key
   parameter logic [127:0] KEY = 128'h0f1e2d3c_4b5a6978_8796a5b4_c3d2e1f0
) (
   // clock
   input wire logic ref_clk,
   // key port
   input wire logic key_rd,
   input wire logic [1:0] key_addr,
   output logic [31:0] key_rdata
);
   initial key_rdata = 32'h0;
   // word n holds key bits 32n+31:32n; output inverts each cycle it is not read
   always @(posedge ref_clk) begin
      if (key_rd) key_rdata <= KEY[key_addr*32 +: 32];
      else key_rdata <= ~key_rdata;
   end
endmodule : cctx_key_mem
`default_nettype wire

// *** content_cipher_tx_auth_ctrl_tb_top.sv ***
// self-checking testbench of the transmit content cipher engine
`timescale 1ns/100ps
`default_nettype none
module content_cipher_tx_auth_ctrl_tb_top;
   logic ref_clk = 1'b0;
   logic nrst = 1'b0;
   cctx_pkg::cctx_csr_req_s csr_req = '0;
   logic [31:0] csr_rdata;
   logic key_rd;
   logic [1:0] key_addr;
   logic [31:0] key_rdata;
   logic vid_in_valid = 1'b0;
   logic vid_in_ready;
   cctx_pkg::cctx_video_s vid_in = '0;
   logic enc_status = 1'b0;
   logic vid_out_valid;
   logic vid_out_ready = 1'b0;
   cctx_pkg::cctx_video_s vid_out;
   int fails = 0;
   int compares = 0;
   logic [1:0] kq [$];

   always #50 ref_clk = ~ref_clk;

   cctx_tx_auth_ctrl #(.OP_CYCLES(4), .OUT_DEPTH(128), .FIFO_DEPTH(8)) u_dut (
      .ref_clk(ref_clk), .nrst(nrst), .csr_req(csr_req),
      .csr_rdata(csr_rdata), .key_rd(key_rd), .key_addr(key_addr),
      .key_rdata(key_rdata), .vid_in_valid(vid_in_valid),
      .vid_in_ready(vid_in_ready), .vid_in(vid_in),
      .encryption_status_signaling(enc_status),
      .vid_out_valid(vid_out_valid),
      .vid_out_ready(vid_out_ready), .vid_out(vid_out));

   cctx_key_mem u_key (.ref_clk(ref_clk), .key_rd(key_rd),
      .key_addr(key_addr), .key_rdata(key_rdata));

   always @(posedge ref_clk) if (nrst && key_rd === 1'b1) kq.push_back(key_addr);

   ////////////////////////////////////////////////////////////////////////
   task automatic check(input string name, input logic [32:0] seen,
         input logic [32:0] exp);
      compares++;
      if (seen !== exp) begin
         fails++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   task automatic csr_write(input logic [1:0] a, input logic [31:0] d);
      csr_req = '{write: 1'b1, read: 1'b0, addr: a, wdata: d};
      @(posedge ref_clk);
      #1 csr_req = '0;
      @(posedge ref_clk);
      #1;
   endtask : csr_write

   task automatic csr_read(input logic [1:0] a, output logic [31:0] d);
      csr_req = '{write: 1'b0, read: 1'b1, addr: a, wdata: 32'h0};
      @(posedge ref_clk);
      #1 d = csr_rdata;
      csr_req = '0;
      @(posedge ref_clk);
      #1;
   endtask : csr_read

   // issue one command and poll its done flag
   task automatic run_cmd(input int i, input bit chk_ok, input logic ok_exp);
      logic [31:0] st;
      logic seen_busy;
      seen_busy = 1'b0;
      csr_write(cctx_pkg::REG_CRYPTO_COMMAND, 32'h1 << i);
      for (int k = 0; k < 400; k++) begin
         csr_read(cctx_pkg::REG_STATUS, st);
         if (st[30] === 1'b1) seen_busy = 1'b1;
         if (seen_busy && st[i] === 1'b1 && st[30] === 1'b0) break;
      end
      check("busy seen", seen_busy, 1'b1);
      check("done flag", st[i], 1'b1);
      check("idle after op", st[30], 1'b0);
      if (chk_ok) check("ok flag", st[31], ok_exp);
   endtask : run_cmd

   function automatic cctx_pkg::cctx_video_s mk(input int n);
      return '{de: 1'b1, aux: n[7:0] + 8'h30, pixel: {3{n[7:0]}}};
   endfunction : mk

   task automatic give_verdict;
      if (fails == 0 && compares > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : give_verdict

   ////////////////////////////////////////////////////////////////////////
   initial begin
      #(100 * 40000);
      fails++;
      give_verdict();
   end

   initial begin
      logic [31:0] st;
      logic [31:0] s0;
      logic [31:0] bad [4];
      bit acc;
      int n;
      cctx_pkg::cctx_video_s w9;
      bad = '{32'h0, 32'h3, 32'h800, 32'h401};
      repeat (16) @(posedge ref_clk);
      #1 nrst = 1'b1;
      for (int k = 0; k < 50; k++) begin
         csr_read(cctx_pkg::REG_STATUS, st);
         if (st[29] === 1'b1) break;
      end
      check("key loaded", st[29], 1'b1);
      check("key reads", kq.size(), 4);
      foreach (kq[k]) check("key addr", kq[k], k);
      // every command once; with no message loaded, compares after the
      // key derivation match and an empty signature check fails
      for (int i = 0; i < 11; i++) begin
         run_cmd(i, 1'b1, i != 1);
      end
      // result bytes of the last generator command, one per read
      for (int k = 0; k < 8; k++) begin
         csr_read(cctx_pkg::REG_MSG_OUT, st);
         check("out byte top", st[31:8], 24'h0);
         check("out byte known", $isunknown(st[7:0]), 1'b0);
      end
      csr_read(cctx_pkg::REG_CRYPTO_COMMAND, st);
      check("cmd reads zero", st, 32'h0);
      csr_read(cctx_pkg::REG_MSG_IN, st);
      check("msg in reads zero", st, 32'h0);
      // signature check with signature and receiver id loaded
      for (int b = 0; b < 389; b++) csr_write(cctx_pkg::REG_MSG_IN, b);
      run_cmd(1, 1'b1, 1'b1);
      // writes that are not one-hot in bits 10:0 do nothing
      csr_read(cctx_pkg::REG_STATUS, s0);
      foreach (bad[j]) begin
         csr_write(cctx_pkg::REG_CRYPTO_COMMAND, bad[j]);
         repeat (3) @(posedge ref_clk);
         #1 csr_read(cctx_pkg::REG_STATUS, st);
         check("bad cmd busy", st[30], 1'b0);
         check("bad cmd done", st[10:0], s0[10:0]);
      end
      // fill the fifo with the sink stalled, plain passthrough
      n = 0;
      vid_in_valid = 1'b1;
      while (n < 12) begin
         vid_in = mk(n);
         acc = vid_in_ready;
         @(posedge ref_clk);
         #1;
         if (!acc) break;
         n++;
      end
      vid_in_valid = 1'b0;
      check("fifo fill", n, 8);
      vid_out_ready = 1'b1;
      for (int k = 0; k < 8; k++) begin
         check("out valid", vid_out_valid, 1'b1);
         check("clear word", vid_out, mk(k));
         @(posedge ref_clk);
         #1;
      end
      check("fifo empty", vid_out_valid, 1'b0);
      // encryption on: content is changed, framing kept
      enc_status = 1'b1;
      vid_out_ready = 1'b0;
      vid_in_valid = 1'b1;
      w9 = mk(9);
      vid_in = w9;
      @(posedge ref_clk);
      #1 vid_in_valid = 1'b0;
      check("enc valid", vid_out_valid, 1'b1);
      check("enc de", vid_out.de, 1'b1);
      check("enc pixel", vid_out.pixel !== w9.pixel, 1'b1);
      give_verdict();
   end
endmodule : content_cipher_tx_auth_ctrl_tb_top
`default_nettype wire
